// *** rtl/pwmg_pkg.sv ***
package pwmg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int         ADDR_W     = 5;     // Byte address width
    localparam int         DATA_W     = 32;    // Avalon data width
    localparam int         DUTY_W     = 10;    // Full duty / time base width
    localparam int         PRE_W      = 4;     // Prescaler counter width

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [4:0] OFF_MODE   = 5'h00; // unit_mode_control
    localparam logic [4:0] OFF_DUTY   = 5'h04; // duty_upper_register
    localparam logic [4:0] OFF_SHADOW = 5'h08; // duty_shadow_register
    localparam logic [4:0] OFF_PERIOD = 5'h0c; // period_register
    localparam logic [4:0] OFF_TCTRL  = 5'h10; // timer_control_register
    localparam logic [4:0] OFF_TCOUNT = 5'h14; // timer_count
    localparam logic [4:0] OFF_PINCTL = 5'h18; // Pin direction and latch

    ////////////////////////////////////////////////////////////////////////
    // Field positions and encodings
    localparam int         DCLOW_LSB  = 4;     // duty_low_field at [5:4]
    localparam logic [1:0] MODE_PWM   = 2'h3;  // Mode bits [3:2] for PWM
    localparam int         TON_BIT    = 2;     // Timer run enable
    localparam logic [1:0] PS_DIV1    = 2'h0;  // Prescale 1:1
    localparam logic [1:0] PS_DIV4    = 2'h1;  // Prescale 1:4, else 1:16
    localparam int         DIR_BIT    = 0;     // pin_direction_bit
    localparam int         LAT_BIT    = 1;     // Port latch value
    localparam int         PIN_BIT    = 2;     // Pin level, read only
    localparam logic [1:0] PHASE_LAST = 2'h3;  // Clocks per timer step - 1

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hff;
    localparam logic       RST_DIR    = 1'b1;  // Pin starts as input

endpackage

// *** rtl/pwmg_top.sv ***
// Notes on behaviour
// - Output duty resolution up to ten bits.
// - Only period, timer, duty, mode and pin control registers steer.
// - High output is on, low is off.
// - Zero duty stays low, full stays high.
// - Mode zero returns pin to port latch.
// - Time base is timer plus two low bits.
// - Shadow register read only in PWM mode.
// - Unimplemented bits read back as zero.
// - Period wrap clears timer, sets pin unless duty is zero, reloads.
// - Time base matching shadow duty clears pin.
// - Duty is upper register plus low field.
// - Divide by one uses clock phase bits.
module pwmg_top
    import pwmg_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [3:0]        byteenable,
    input  wire logic [DATA_W-1:0] writedata,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    // Output pin
    output logic                   pwm_output_pin_o,
    output logic                   pwm_output_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding shared by the read and write paths
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [4:0]        off);
        hit = (a[ADDR_W-1:2] == off[4:2]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0]       mode_ctl, next_mode_ctl;     // unit_mode_control
    logic [7:0]       duty_up, next_duty_up;       // duty_upper_register
    logic [7:0]       shadow, next_shadow;         // duty_shadow_register
    logic [1:0]       duty_latch, next_duty_latch; // Hidden low duty bits
    logic [7:0]       period, next_period;         // period_register
    logic [7:0]       tctrl, next_tctrl;           // timer_control_register
    logic [7:0]       timer, next_timer;           // timer_count
    logic [1:0]       phase, next_phase;           // System clock phase
    logic [PRE_W-1:0] pre, next_pre;               // Prescaler count
    logic             pin_dir, next_pin_dir;       // pin_direction_bit
    logic             pin_lat, next_pin_lat;       // Port latch
    logic             pwm_q, next_pwm_q;           // Waveform level
    logic             ack, next_ack;               // Bus answer phase
    logic [DATA_W-1:0] next_readdata;

    // Derived terms
    logic             pwm_mode;   // Unit in standard PWM mode
    logic             tick;       // Timer increments this cycle
    logic             wrap;       // Timer count equals period on tick
    logic [1:0]       low2;       // Low time-base bits
    logic [DUTY_W-1:0] tbase;     // Ten-bit time base
    logic [DUTY_W-1:0] duty_full; // Software duty value
    logic             match;      // Time base reaches duty next edge
    logic             step;       // Time base advances next edge
    logic             wr_go;      // Write accepted this cycle
    logic             rd_go;      // Read sampled this cycle

    ////////////////////////////////////////////////////////////////////////
    // Time base and match
    always_comb begin
        pwm_mode  = (mode_ctl[3:2] == MODE_PWM);
        // Prescale terminal count depends on the selected ratio
        case (tctrl[1:0])
            PS_DIV1: tick = (phase == PHASE_LAST);
            PS_DIV4: tick = (phase == PHASE_LAST) && (pre[1:0] == 2'h3);
            default: tick = (phase == PHASE_LAST) && (pre == 4'hf);
        endcase
        tick      = tick && tctrl[TON_BIT];
        wrap      = tick && (timer == period);
        // Low bits from the clock phase at 1:1, else the prescaler
        case (tctrl[1:0])
            PS_DIV1: low2 = phase;
            PS_DIV4: low2 = pre[1:0];
            default: low2 = pre[3:2];
        endcase
        tbase     = {timer, low2};
        duty_full = {duty_up, mode_ctl[DCLOW_LSB+1:DCLOW_LSB]};
        // Look one step ahead: the pin flop is registered, so clearing
        // it on the step before the match makes it low exactly while
        // the time base equals the duty, giving duty times unit on time
        case (tctrl[1:0])
            PS_DIV1: step = 1'b1;
            PS_DIV4: step = (phase == PHASE_LAST);
            default: step = (phase == PHASE_LAST) && (pre[1:0] == 2'h3);
        endcase
        step      = step && tctrl[TON_BIT];
        // A duty above the period never matches, so the pin stays high
        match     = step
                    && (tbase + 10'h001 == {shadow, duty_latch});
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then the answer
    always_comb begin
        // Every request costs one wait cycle; read data are captured
        // while waitrequest is high and stand from the next cycle on
        waitrequest = (read || write) && !ack;
        wr_go       = write && ack;
        rd_go       = read && !ack;
        next_ack    = (read || write) && !ack;
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer, prescaler and waveform next state
    always_comb begin
        next_phase      = phase + 2'h1;
        next_pre        = pre;
        next_timer      = timer;
        next_shadow     = shadow;
        next_duty_latch = duty_latch;
        next_pwm_q      = pwm_q;
        if (tctrl[TON_BIT] && phase == PHASE_LAST) begin
            next_pre = pre + 4'h1;
        end
        if (tick) begin
            next_timer = timer + 8'h01;
        end
        // Ordinary stepping may clear the pin on a match
        if (pwm_mode && match) begin
            next_pwm_q = 1'b0;
        end
        // Period end: restart, reload buffer, set unless duty is zero
        if (wrap) begin
            next_timer = 8'h00;
            next_pre   = '0;
            if (pwm_mode) begin
                next_shadow     = duty_up;
                next_duty_latch = duty_full[1:0];
                next_pwm_q      = (duty_full != '0);
            end
        end
        // Timer count may be preset while it is stopped or running
        if (wr_go && byteenable[0] && hit(address, OFF_TCOUNT)) begin
            next_timer = writedata[7:0];
        end
        // Shadow is writable only outside PWM mode
        if (wr_go && byteenable[0] && hit(address, OFF_SHADOW)
            && !pwm_mode) begin
            next_shadow = writedata[7:0];
        end
        if (!pwm_mode) begin
            next_pwm_q = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers next state
    always_comb begin
        next_mode_ctl = mode_ctl;
        next_duty_up  = duty_up;
        next_period   = period;
        next_tctrl    = tctrl;
        next_pin_dir  = pin_dir;
        next_pin_lat  = pin_lat;
        // Duty halves may be written at any time; buffering hides it
        if (wr_go && byteenable[0]) begin
            if (hit(address, OFF_MODE)) begin
                next_mode_ctl = {2'h0, writedata[5:0]};
            end
            if (hit(address, OFF_DUTY)) begin
                next_duty_up = writedata[7:0];
            end
            if (hit(address, OFF_PERIOD)) begin
                next_period = writedata[7:0];
            end
            if (hit(address, OFF_TCTRL)) begin
                next_tctrl = {5'h00, writedata[2:0]};
            end
            if (hit(address, OFF_PINCTL)) begin
                next_pin_dir = writedata[DIR_BIT];
                next_pin_lat = writedata[LAT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured on the wait cycle; spare bits read zero
    always_comb begin
        next_readdata = readdata;
        if (rd_go) begin
            next_readdata = '0;
            if (hit(address, OFF_MODE)) begin
                next_readdata[7:0] = mode_ctl;
            end else if (hit(address, OFF_DUTY)) begin
                next_readdata[7:0] = duty_up;
            end else if (hit(address, OFF_SHADOW)) begin
                next_readdata[7:0] = shadow;
            end else if (hit(address, OFF_PERIOD)) begin
                next_readdata[7:0] = period;
            end else if (hit(address, OFF_TCTRL)) begin
                next_readdata[7:0] = tctrl;
            end else if (hit(address, OFF_TCOUNT)) begin
                next_readdata[7:0] = timer;
            end else if (hit(address, OFF_PINCTL)) begin
                next_readdata[DIR_BIT] = pin_dir;
                next_readdata[LAT_BIT] = pin_lat;
                next_readdata[PIN_BIT] = pwm_output_pin_o;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers; all defaults restored by reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_ctl   <= RST_BYTE;
            duty_up    <= RST_BYTE;
            shadow     <= RST_BYTE;
            duty_latch <= 2'h0;
            period     <= RST_PERIOD;
            tctrl      <= RST_BYTE;
            timer      <= RST_BYTE;
            phase      <= 2'h0;
            pre        <= '0;
            pin_dir    <= RST_DIR;
            pin_lat    <= 1'b0;
            pwm_q      <= 1'b0;
            ack        <= 1'b0;
            readdata   <= '0;
        end else begin
            mode_ctl   <= next_mode_ctl;
            duty_up    <= next_duty_up;
            shadow     <= next_shadow;
            duty_latch <= next_duty_latch;
            period     <= next_period;
            tctrl      <= next_tctrl;
            timer      <= next_timer;
            phase      <= next_phase;
            pre        <= next_pre;
            pin_dir    <= next_pin_dir;
            pin_lat    <= next_pin_lat;
            pwm_q      <= next_pwm_q;
            ack        <= next_ack;
            readdata   <= next_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin: waveform in PWM mode, port latch otherwise
    always_comb begin
        // High level is the on state of the load
        pwm_output_pin_o  = pwm_mode ? pwm_q : pin_lat;
        // Drive only once software has cleared the direction bit
        pwm_output_pin_oe = !pin_dir;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_RELEASE: assert property (
        mode_ctl == 8'h00 |-> pwm_output_pin_o == pin_lat)
        else $error("Pin not under port control in mode zero");
    AST_WRAP: assert property (
        pwm_mode && wrap && !wr_go
        |=> timer == 8'h00 && shadow == $past(duty_up))
        else $error("Period end did not clear timer and reload");
    AST_SET: assert property (
        pwm_mode && wrap && !wr_go
        |=> pwm_q == ($past(duty_full) != 10'h000))
        else $error("Pin level wrong after period end");
    AST_CLEAR: assert property (
        pwm_mode && match && !wrap && !wr_go |=> !pwm_q)
        else $error("Pin not cleared on duty match");
    AST_HOLD: assert property (
        pwm_mode && pwm_q && !match && !wrap && !wr_go |=> pwm_q)
        else $error("Pin dropped without a match");
    AST_SHADOW_RO: assert property (
        pwm_mode && !wrap && wr_go && hit(address, OFF_SHADOW)
        |=> $stable(shadow))
        else $error("Shadow changed by software in PWM mode");
    AST_PHASE: assert property (
        tctrl[1:0] == PS_DIV1 |-> low2 == phase)
        else $error("Low time-base bits not from clock phase");
    AST_STEP: assert property (
        tick && !wrap && !wr_go |=> timer == $past(timer) + 8'h01)
        else $error("Timer did not step on tick");
    AST_ZERO: assert property (
        rd_go |=> readdata[31:8] == 24'h000000 && !waitrequest)
        else $error("Upper read bits not zero or no answer");
    AST_OE: assert property (
        pin_dir |-> !pwm_output_pin_oe)
        else $error("Pin driven while direction is input");

    COV_WRAP_SET: cover property (pwm_mode && wrap ##1 pwm_q);
    COV_MATCH: cover property (pwm_q ##1 !pwm_q && pwm_mode);
    COV_RELEASE: cover property (pwm_mode ##1 mode_ctl == 8'h00);
    COV_SHADOW_WR: cover property (wr_go && hit(address, OFF_SHADOW));
    COV_ZERO_DUTY: cover property (pwm_mode && wrap && duty_full == '0);

endmodule

// *** sim/pwmg_load.sv ***
////////////////////////////////////////////////////////////////////////////
// Load on the output pin: a pulled-down line that times on and off spans
module pwmg_load (
    // System clock used as the measuring tick
    input  wire logic        clock,
    // Pin as driven by the block
    input  wire logic        pin_o,
    input  wire logic        pin_oe,
    // Measurements for the bench
    output logic             level,
    output logic [15:0]      high_len,
    output logic [15:0]      period_len,
    output logic [15:0]      rises
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] run_cnt = 16'h0000; // Cycles since the last rise
    logic [15:0] hi_cnt  = 16'h0000; // Cycles high since the last rise
    logic        last    = 1'b0;     // Level one cycle back

    // Undriven pin sinks to the pull-down, never holds a stale level
    assign level = pin_oe ? pin_o : 1'b0;

    logic [15:0] high_q   = 16'h0000; // Last on span
    logic [15:0] period_q = 16'h0000; // Last rise to rise span
    logic [15:0] rise_q   = 16'h0000; // Rises seen so far

    assign high_len   = high_q;
    assign period_len = period_q;
    assign rises      = rise_q;

    ////////////////////////////////////////////////////////////////////////
    // High level is on time, a rise starts a new period
    always @(posedge clock) begin
        last <= level;
        if (level && !last) begin
            period_q <= run_cnt;
            run_cnt  <= 16'h0001;
            hi_cnt   <= 16'h0001;
            rise_q   <= rise_q + 16'h0001;
        end else begin
            run_cnt <= run_cnt + 16'h0001;
            if (level) begin
                hi_cnt <= hi_cnt + 16'h0001;
            end
        end
        // Fall closes the on span
        if (!level && last) begin
            high_q <= hi_cnt;
        end
    end
endmodule

// *** sim/pwmg_top_bench.sv ***
////////////////////////////////////////////////////////////////////////////
// Bench: bus tasks, one task per scenario, verdict in close_out
module pwmg_top_bench
    import pwmg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clock       = 1'b0;
    logic              rstn        = 1'b0;
    logic [ADDR_W-1:0] address     = 5'h00;
    logic              read        = 1'b0;
    logic              write       = 1'b0;
    logic [3:0]        byteenable  = 4'h1;
    logic [DATA_W-1:0] writedata   = 32'h0000_0000;
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
    logic              pin_o;
    logic              pin_oe;
    logic              level;
    logic [15:0]       high_len;
    logic [15:0]       period_len;
    logic [15:0]       rises;
    int                err_total   = 0;
    int                check_count = 0;

    pwmg_top dut (.clock(clock), .rstn(rstn), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .pwm_output_pin_o(pin_o),
        .pwm_output_pin_oe(pin_oe));
    pwmg_load load (.clock(clock), .pin_o(pin_o), .pin_oe(pin_oe),
        .level(level), .high_len(high_len), .period_len(period_len),
        .rises(rises));

    // 4 ns system clock
    initial begin
        forever #2 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle; request held until an edge sees waitrequest low
    task automatic bus_go(input logic rd, input logic [4:0] a,
                          input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= {24'h000000, d};
        read <= rd;
        write <= !rd;
        // Values read just after the edge are those the slave sampled
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        check("bus edges", 32'd2, n);
        @(posedge clock);
    endtask

    task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus_go(1'b0, a, d, q);
    endtask

    task automatic bus_rd(input logic [4:0] a, output logic [31:0] q);
        bus_go(1'b1, a, 8'h00, q);
    endtask

    task automatic wait_rises(input int n);
        int r0;
        int k;
        r0 = rises;
        k = 0;
        while (rises < r0 + n && k < 5000) begin
            @(posedge clock);
            k++;
        end
        check("rise count", r0 + n, rises);
    endtask

    // Cycles within a span where the pin left the given level
    task automatic hold_cnt(input logic lvl, input int cyc, output int bad);
        bad = 0;
        repeat (cyc) begin
            @(negedge clock);
            if (level !== lvl) bad++;
        end
        @(posedge clock);
    endtask

    task automatic set_pwm(input logic [1:0] ps, input logic [7:0] per,
                           input logic [9:0] duty);
        bus_wr(OFF_TCTRL, 8'h00);
        bus_wr(OFF_TCOUNT, 8'h00);
        bus_wr(OFF_PERIOD, per);
        bus_wr(OFF_DUTY, duty[9:2]);
        bus_wr(OFF_MODE, {2'h0, duty[1:0], MODE_PWM, 2'h0});
        bus_wr(OFF_PINCTL, 8'h00);
        bus_wr(OFF_TCTRL, {5'h00, 1'b1, ps});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Defaults after reset, unmapped word last
    task automatic t_defaults;
        logic [4:0]  offs [8] = '{OFF_MODE, OFF_DUTY, OFF_SHADOW, OFF_PERIOD,
                                  OFF_TCTRL, OFF_TCOUNT, OFF_PINCTL, 5'h1c};
        logic [31:0] exps [8] = '{32'h0, 32'h0, 32'h0, 32'hff,
                                  32'h0, 32'h0, 32'h1, 32'h0};
        logic [31:0] q;
        check("pin enable", 32'h0, {31'h0, pin_oe});
        for (int i = 0; i < 8; i++) begin
            bus_rd(offs[i], q);
            check("reset value", exps[i], q);
        end
    endtask

    // Unused bit positions read as zero
    task automatic t_unused;
        logic [31:0] q;
        bus_wr(OFF_MODE, 8'hc3);
        bus_rd(OFF_MODE, q);
        check("mode bits", 32'h03, q);
        bus_wr(OFF_TCTRL, 8'hf8);
        bus_rd(OFF_TCTRL, q);
        check("timer ctl bits", 32'h00, q);
        bus_wr(5'h1c, 8'hff);
        bus_rd(5'h1c, q);
        check("unmapped", 32'h00, q);
        bus_wr(OFF_MODE, 8'h00);
    endtask

    // Period and on time for one prescale setting
    task automatic t_wave(input logic [1:0] ps, input logic [7:0] per,
                          input logic [9:0] duty);
        logic [31:0] unit;
        unit = (ps == PS_DIV1) ? 32'd1 : (ps == PS_DIV4) ? 32'd4 : 32'd16;
        set_pwm(ps, per, duty);
        wait_rises(3);
        check("period", 32'd4 * ({24'h0, per} + 32'd1) * unit,
              {16'h0, period_len});
        check("on time", {22'h0, duty} * unit,
              {16'h0, high_len});
    endtask

    // Double buffering of the duty value
    task automatic t_shadow;
        logic [31:0] q;
        wait_rises(1);
        bus_wr(OFF_DUTY, 8'h10);
        bus_rd(OFF_SHADOW, q);
        check("shadow held", 32'hff, q);
        bus_wr(OFF_SHADOW, 8'h55);
        bus_rd(OFF_SHADOW, q);
        check("shadow write", 32'hff, q);
        wait_rises(1);
        bus_rd(OFF_SHADOW, q);
        check("shadow reload", 32'h10, q);
    endtask

    // Zero duty stays off, overlong duty stays on, then release to port
    task automatic t_flat;
        int bad;
        set_pwm(PS_DIV1, 8'h03, 10'h000);
        repeat (40) @(posedge clock);
        hold_cnt(1'b0, 48, bad);
        check("zero duty", 32'h0, bad);
        set_pwm(PS_DIV1, 8'h03, 10'h3ff);
        repeat (40) @(posedge clock);
        hold_cnt(1'b1, 48, bad);
        check("full duty", 32'h0, bad);
        bus_wr(OFF_MODE, 8'h00);
        check("released pin", 32'h0, {31'h0, pin_o});
        bus_wr(OFF_PINCTL, 8'h02);
        hold_cnt(1'b1, 40, bad);
        check("port latch", 32'h0, bad);
    endtask

    // Reset in mid run
    task automatic t_rerun;
        logic [31:0] q;
        set_pwm(PS_DIV1, 8'h03, 10'h008);
        wait_rises(2);
        rstn <= 1'b0;
        repeat (8) @(posedge clock);
        check("reset pin", 32'h0, {30'h0, pin_oe, pin_o});
        rstn <= 1'b1;
        @(posedge clock);
        bus_rd(OFF_PERIOD, q);
        check("reset period", 32'hff, q);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        t_defaults();
        t_unused();
        t_wave(PS_DIV1, 8'h03, 10'h00b);
        t_wave(PS_DIV4, 8'h03, 10'h00b);
        t_wave(2'h2, 8'h03, 10'h00b);
        t_wave(2'h3, 8'h03, 10'h005);
        t_wave(PS_DIV1, 8'hff, 10'h3fe);
        t_shadow();
        t_flat();
        t_rerun();
        close_out();
    end

    // Run needs under 10000 cycles; cut a hang well beyond that
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        close_out();
    end
endmodule
